// ==== rtl/hall_mode_defines.vh ====
// Offsets, field positions, codes and timing figures for the sensor mode control
`ifndef HALL_MODE_DEFINES_VH
`define HALL_MODE_DEFINES_VH

`define REG_ADDR_OVR 7'h0c
`define REG_ADDR_OVR_RST 8'h00
`define ADDR_OVR_EN_BIT 0
`define ADDR_OVR_MSB 7
`define ADDR_OVR_LSB 1
`define ADDR_STRAP_BASE 7'h34

`define PWR_STANDBY 2'h0
`define PWR_SLEEP 2'h1
`define PWR_CONT 2'h2
`define PWR_WAKESLEEP 2'h3

`define WATCH_ANGLE 2'h1
`define WATCH_FIELD 2'h2

`define ROUTE_NONE 3'h0
`define ROUTE_PIN_A 3'h1
`define ROUTE_PIN_B 3'h2
`define ROUTE_SCL 3'h3
`define ROUTE_SCL_IDLE 3'h4
`define ROUTE_UNIPOLAR 3'h5
`define ROUTE_OMNIPOLAR 3'h6

`define AVG_MAX 3'h5
`define INTERVAL_MAX 4'hc

`define CLK_HZ 250000000
`define CLK_PERIOD_NS 4
`define INT_PULSE_NS 5000
`define INT_PULSE_CYC ((`INT_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define MS_NS 1000000
`define MS_CYC (`MS_NS / `CLK_PERIOD_NS)
`define WAIT_MS 10

`endif

// ==== rtl/hall_mode_ctrl.v ====
// Power-state, wake-on-change, address and conversion control of the field sensor
//
// Overview of operation
// [RULE_01] Wake-on-change watches one field axis or the angle, signals via routing field.
// [RULE_02] Each wake-on-change interrupt loads the causing sample as new reference.
// [RULE_03] Unipolar or omnipolar switch routing disables wake-on-change.
// [RULE_04] Selector 2h: axis change beyond field hysteresis interrupts.
// [RULE_05] Selector 1h: angle change beyond angle hysteresis interrupts.
// [RULE_06] Angle steps 0 to 359 count as full 359, no wrap shortening.
// [RULE_07] Wake-on-change works in standby, continuous and wake-and-sleep.
// [RULE_08] Address strap sampled only in standby or continuous mode.
// [RULE_09] Override enable set: answer to programmed 7-bit address.
// [RULE_10] Default address follows strap: 34h, 35h, 36h, 37h.
// [RULE_11] Host programs address override before using sleep or wake-and-sleep.
// [RULE_12] Separate X/Y and Z range selectors; 1h doubles the span.
// [RULE_13] Averaging code 0h-5h and axis count set the conversion rate.
// [RULE_14] Trigger during a running conversion is ignored; no restart.
// [RULE_15] Power-up enters standby, ready for commands.
// [RULE_16] Standby converts on bus trigger bit or interrupt pin.
// [RULE_17] Standby keeps the latest completed results.
// [RULE_18] Sleep keeps configuration, drops results; bus or pin wakes to standby.
// [RULE_19] Wake-and-sleep measures per interval; hit enters fixed wait, then resumes.
// [RULE_20] Bus activity or interrupt pin during wake-and-sleep returns to standby; the post-hit wait state ignores both.
// [RULE_21] A read after an interrupt puts the device in standby.
// [RULE_22] Continuous mode converts repeatedly; results stay readable.
// [RULE_23] Routing decode: none, pin, pin, SCL, SCL unless busy, switches.
// [RULE_24] Interval choices 1 to 20000 ms in thirteen steps.
// [RULE_25] Results freeze at start; mid-transaction result lands after stop.
`timescale 1ns/1ps
`include "hall_mode_defines.vh"

module hall_mode_ctrl #(
	parameter MS_CYCLES = `MS_CYC,
	parameter RATE_DIV = 1
) (
	input wire CLK_I, // 250 MHz clock
	input wire RST_B_I, // Asynchronous reset, active low
	input wire SCL_I, // Bus clock pin level
	input wire SDA_I, // Bus data pin level
	output wire SCL_O, // Bus clock drive value
	output wire SCL_OE_O, // Bus clock drive enable
	input wire INT_B_I, // Interrupt pin level
	output wire INT_B_O, // Interrupt pin drive value
	output wire INT_OE_O, // Interrupt pin drive enable
	input wire [1:0] ADDR_STRAP_I, // Strap pin level code
	input wire [6:0] REG_PTR_I, // Register pointer from bus layer
	input wire REG_WR_I, // Register write strobe
	input wire [7:0] REG_WDATA_I, // Register write data
	output wire [7:0] REG_RDATA_O, // Register read data
	input wire TRIG_I, // Conversion trigger bit clocked in
	input wire RD_ADDRESSED_I, // Device addressed for a read
	input wire MODE_WR_I, // Power state written
	input wire [1:0] MODE_I, // Power state selector
	input wire [1:0] CHANGE_WATCH_SELECT_I, // Wake-on-change source
	input wire [2:0] FIELD_AXIS_ENABLE_I, // Enabled axes Z,Y,X
	input wire [15:0] FIELD_HYSTERESIS_I, // Field change threshold
	input wire [15:0] ANGLE_HYSTERESIS_I, // Angle change threshold
	input wire [2:0] INT_ROUTE_I, // Interrupt routing field
	input wire [2:0] AVERAGING_SELECT_I, // Averaging code
	input wire [3:0] INTERVAL_SELECT_I, // Wake-and-sleep interval code
	input wire XY_RANGE_I, // X/Y range selector
	input wire Z_RANGE_I, // Z range selector
	input wire [15:0] X_I, // Front-end X sample
	input wire [15:0] Y_I, // Front-end Y sample
	input wire [15:0] Z_I, // Front-end Z sample
	input wire [15:0] ANGLE_I, // Front-end angle in degrees
	output reg [6:0] BUS_ADDR_O, // Address the device answers to
	output reg XY_SPAN_O, // Front-end X/Y span control
	output reg Z_SPAN_O, // Front-end Z span control
	output reg CONV_BUSY_O, // Conversion running
	output reg [15:0] RES_X_O, // Result X
	output reg [15:0] RES_Y_O, // Result Y
	output reg [15:0] RES_Z_O, // Result Z
	output reg [15:0] RES_ANGLE_O, // Result angle
	output reg [2:0] PWR_STATE_O // Current power state
);

	localparam [2:0] ST_STBY = 3'd0;
	localparam [2:0] ST_SLEEP = 3'd1;
	localparam [2:0] ST_CONT = 3'd2;
	localparam [2:0] ST_WS = 3'd3;
	localparam [2:0] ST_WAIT = 3'd4;

	////////////////////////////////////////////////////////////////////////////
	// Decode helpers

	// Update rate in tenths of kSPS by averaging code and axis count
	function [7:0] rate_dk;
		input [2:0] avg;
		input [1:0] naxes;
		reg [2:0] a;
		begin
			a = (avg > `AVG_MAX) ? `AVG_MAX : avg;
			case ({a, naxes})
				{3'd0, 2'd2}: rate_dk = 8'd133;
				{3'd0, 2'd3}: rate_dk = 8'd100;
				{3'd1, 2'd1}: rate_dk = 8'd133;
				{3'd1, 2'd2}: rate_dk = 8'd80;
				{3'd1, 2'd3}: rate_dk = 8'd57;
				{3'd2, 2'd1}: rate_dk = 8'd80;
				{3'd2, 2'd2}: rate_dk = 8'd44;
				{3'd2, 2'd3}: rate_dk = 8'd31;
				{3'd3, 2'd1}: rate_dk = 8'd44;
				{3'd3, 2'd2}: rate_dk = 8'd24;
				{3'd3, 2'd3}: rate_dk = 8'd16;
				{3'd4, 2'd1}: rate_dk = 8'd24;
				{3'd4, 2'd2}: rate_dk = 8'd12;
				{3'd4, 2'd3}: rate_dk = 8'd8;
				{3'd5, 2'd1}: rate_dk = 8'd12;
				{3'd5, 2'd2}: rate_dk = 8'd6;
				{3'd5, 2'd3}: rate_dk = 8'd4;
				default: rate_dk = 8'd200;
			endcase
		end
	endfunction

	// Interval length in milliseconds
	function [14:0] interval_ms;
		input [3:0] code;
		begin
			case (code)
				4'd0: interval_ms = 15'd1;
				4'd1: interval_ms = 15'd5;
				4'd2: interval_ms = 15'd10;
				4'd3: interval_ms = 15'd15;
				4'd4: interval_ms = 15'd20;
				4'd5: interval_ms = 15'd30;
				4'd6: interval_ms = 15'd50;
				4'd7: interval_ms = 15'd100;
				4'd8: interval_ms = 15'd500;
				4'd9: interval_ms = 15'd1000;
				4'd10: interval_ms = 15'd2000;
				4'd11: interval_ms = 15'd5000;
				default: interval_ms = 15'd20000;
			endcase
		end
	endfunction

	// Magnitude of a difference; signed for field, plain for angle
	function [16:0] abs_diff;
		input [15:0] a;
		input [15:0] b;
		input is_signed;
		reg [16:0] d;
		begin
			if (is_signed)
				d = {a[15], a} - {b[15], b};
			else
				d = {1'b0, a} - {1'b0, b};
			if (is_signed ? d[16] : (a < b))
				abs_diff = is_signed ? (17'd0 - d) : ({1'b0, b} - {1'b0, a});
			else
				abs_diff = d;
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Reset release and pin synchronisers

	reg [1:0] rst_sync_q;
	wire rst_b = rst_sync_q[1];
	reg [1:0] scl_s_q, sda_s_q, int_s_q;
	reg [1:0] strap0_s_q, strap1_s_q;
	reg scl_d1_q, sda_d1_q, int_d1_q;

	always @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I)
			rst_sync_q <= 2'b00;
		else
			rst_sync_q <= {rst_sync_q[0], 1'b1};
	end

	always @(posedge CLK_I or negedge rst_b) begin
		if (!rst_b) begin
			scl_s_q <= 2'b11;
			sda_s_q <= 2'b11;
			int_s_q <= 2'b11;
			strap0_s_q <= 2'b00;
			strap1_s_q <= 2'b00;
			scl_d1_q <= 1'b1;
			sda_d1_q <= 1'b1;
			int_d1_q <= 1'b1;
		end else begin
			scl_s_q <= {scl_s_q[0], SCL_I};
			sda_s_q <= {sda_s_q[0], SDA_I};
			int_s_q <= {int_s_q[0], INT_B_I};
			strap0_s_q <= {strap0_s_q[0], ADDR_STRAP_I[0]};
			strap1_s_q <= {strap1_s_q[0], ADDR_STRAP_I[1]};
			scl_d1_q <= scl_s_q[1];
			sda_d1_q <= sda_s_q[1];
			int_d1_q <= int_s_q[1];
		end
	end

	// Start and stop seen as data edges while the clock line stays high
	wire bus_start = scl_s_q[1] && scl_d1_q && sda_d1_q && !sda_s_q[1];
	wire bus_stop = scl_s_q[1] && scl_d1_q && !sda_d1_q && sda_s_q[1];
	reg bus_busy_q;
	reg int_drv_q;
	// Own pulse would look like a pin trigger, so it is masked
	wire int_fall = int_d1_q && !int_s_q[1] && !int_drv_q;

	////////////////////////////////////////////////////////////////////////////
	// Address register and strap

	reg [7:0] addr_ovr_q;
	reg [1:0] strap_q;
	reg [7:0] rdata_q;
	reg [2:0] state_q, state_d;

	always @(posedge CLK_I or negedge rst_b) begin
		if (!rst_b) begin
			addr_ovr_q <= `REG_ADDR_OVR_RST;
			strap_q <= 2'b00;
			rdata_q <= 8'h00;
			BUS_ADDR_O <= `ADDR_STRAP_BASE;
			bus_busy_q <= 1'b0;
		end else begin
			if (REG_WR_I && REG_PTR_I == `REG_ADDR_OVR)
				addr_ovr_q <= REG_WDATA_I;
			rdata_q <= (REG_PTR_I == `REG_ADDR_OVR) ? addr_ovr_q : 8'h00;
			// [RULE_08] Strap sampling window
			if (state_q == ST_STBY || state_q == ST_CONT)
				strap_q <= {strap1_s_q[1], strap0_s_q[1]};
			// [RULE_09] Programmed address wins; [RULE_11] host sets it for low-power use
			if (addr_ovr_q[`ADDR_OVR_EN_BIT])
				BUS_ADDR_O <= addr_ovr_q[`ADDR_OVR_MSB:`ADDR_OVR_LSB];
			else
				// [RULE_10] Strap-based default
				BUS_ADDR_O <= `ADDR_STRAP_BASE + {5'd0, strap_q};
			if (bus_start)
				bus_busy_q <= 1'b1;
			else if (bus_stop)
				bus_busy_q <= 1'b0;
		end
	end

	assign REG_RDATA_O = rdata_q;

	////////////////////////////////////////////////////////////////////////////
	// Conversion timing

	wire [1:0] naxes = {1'b0, FIELD_AXIS_ENABLE_I[0]} + {1'b0, FIELD_AXIS_ENABLE_I[1]}
		+ {1'b0, FIELD_AXIS_ENABLE_I[2]};
	// [RULE_13] Period from rate table
	wire [31:0] conv_cycles = `CLK_HZ / (rate_dk(AVERAGING_SELECT_I, naxes) * 100) / RATE_DIV;
	reg [31:0] conv_cnt_q;
	reg conv_req;
	wire conv_done = CONV_BUSY_O && conv_cnt_q <= 32'd1;
	// [RULE_14] No restart while busy
	wire conv_start = conv_req && !CONV_BUSY_O;

	always @(posedge CLK_I or negedge rst_b) begin
		if (!rst_b) begin
			CONV_BUSY_O <= 1'b0;
			conv_cnt_q <= 32'd0;
			XY_SPAN_O <= 1'b0;
			Z_SPAN_O <= 1'b0;
		end else begin
			// [RULE_12] Range applied per conversion
			if (conv_start) begin
				CONV_BUSY_O <= 1'b1;
				conv_cnt_q <= conv_cycles;
				XY_SPAN_O <= XY_RANGE_I;
				Z_SPAN_O <= Z_RANGE_I;
			end else if (conv_done) begin
				CONV_BUSY_O <= 1'b0;
				conv_cnt_q <= 32'd0;
			end else if (CONV_BUSY_O) begin
				conv_cnt_q <= conv_cnt_q - 32'd1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Wake-on-change compare

	wire switch_route = INT_ROUTE_I == `ROUTE_UNIPOLAR || INT_ROUTE_I == `ROUTE_OMNIPOLAR;
	wire pin_route = INT_ROUTE_I == `ROUTE_PIN_A || INT_ROUTE_I == `ROUTE_PIN_B;
	wire scl_route = INT_ROUTE_I == `ROUTE_SCL || INT_ROUTE_I == `ROUTE_SCL_IDLE;
	wire watch_angle = CHANGE_WATCH_SELECT_I == `WATCH_ANGLE;
	wire watch_field = CHANGE_WATCH_SELECT_I == `WATCH_FIELD;
	// [RULE_03] Switch routing turns the watch off
	wire watch_on = (watch_angle || watch_field) && !switch_route;
	wire [15:0] field_new = FIELD_AXIS_ENABLE_I[0] ? X_I :
		(FIELD_AXIS_ENABLE_I[1] ? Y_I : Z_I);
	wire [15:0] watch_new = watch_angle ? ANGLE_I : field_new;
	reg [15:0] ref_q;
	reg ref_valid_q;
	// [RULE_06] Plain difference, 0 to 359 counts as 359
	wire [16:0] change = abs_diff(watch_new, ref_q, watch_field);
	// [RULE_04] Field threshold [RULE_05] angle threshold
	wire [16:0] hyst = {1'b0, watch_angle ? ANGLE_HYSTERESIS_I : FIELD_HYSTERESIS_I};
	// [RULE_07] Evaluated on every conversion in any measuring state
	wire woc_hit = conv_done && watch_on && ref_valid_q && change > hyst
		&& (pin_route || scl_route);

	always @(posedge CLK_I or negedge rst_b) begin
		if (!rst_b) begin
			ref_q <= 16'h0000;
			ref_valid_q <= 1'b0;
		end else if (!watch_on) begin
			ref_valid_q <= 1'b0;
		end else if (conv_done && (woc_hit || !ref_valid_q)) begin
			// [RULE_02] Causing sample becomes the reference
			ref_q <= watch_new;
			ref_valid_q <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Interrupt drive

	localparam [15:0] INT_PULSE_LEN = `INT_PULSE_CYC;
	reg [15:0] int_cnt_q;
	reg scl_drv_q;
	reg int_pend_q;

	always @(posedge CLK_I or negedge rst_b) begin
		if (!rst_b) begin
			int_cnt_q <= 16'd0;
			int_drv_q <= 1'b0;
			scl_drv_q <= 1'b0;
		end else if (woc_hit && int_cnt_q == 16'd0) begin
			// [RULE_01] Fixed-width pulse on the routed pin
			int_cnt_q <= INT_PULSE_LEN;
			// [RULE_23] Route decode
			int_drv_q <= pin_route;
			scl_drv_q <= INT_ROUTE_I == `ROUTE_SCL
				|| (INT_ROUTE_I == `ROUTE_SCL_IDLE && !bus_busy_q);
		end else if (int_cnt_q != 16'd0) begin
			int_cnt_q <= int_cnt_q - 16'd1;
			if (int_cnt_q == 16'd1) begin
				int_drv_q <= 1'b0;
				scl_drv_q <= 1'b0;
			end
		end
	end

	assign INT_B_O = 1'b0;
	assign INT_OE_O = int_drv_q;
	assign SCL_O = 1'b0;
	assign SCL_OE_O = scl_drv_q;

	////////////////////////////////////////////////////////////////////////////
	// Result registers

	reg [15:0] held_x_q, held_y_q, held_z_q, held_a_q;
	reg held_pend_q;

	always @(posedge CLK_I or negedge rst_b) begin
		if (!rst_b) begin
			{held_x_q, held_y_q, held_z_q, held_a_q} <= 64'h0;
			held_pend_q <= 1'b0;
			{RES_X_O, RES_Y_O, RES_Z_O, RES_ANGLE_O} <= 64'h0;
		end else if (state_q == ST_SLEEP) begin
			// [RULE_18] Results not retained in sleep
			held_pend_q <= 1'b0;
			{RES_X_O, RES_Y_O, RES_Z_O, RES_ANGLE_O} <= 64'h0;
		end else if (conv_done && (bus_busy_q || bus_start)) begin
			// [RULE_25] Frozen during a transaction
			{held_x_q, held_y_q, held_z_q, held_a_q} <= {X_I, Y_I, Z_I, ANGLE_I};
			held_pend_q <= 1'b1;
		end else if (conv_done) begin
			// [RULE_17] [RULE_22] Latest completed sample kept
			{RES_X_O, RES_Y_O, RES_Z_O, RES_ANGLE_O} <= {X_I, Y_I, Z_I, ANGLE_I};
		end else if (bus_stop && held_pend_q) begin
			{RES_X_O, RES_Y_O, RES_Z_O, RES_ANGLE_O} <= {held_x_q, held_y_q, held_z_q, held_a_q};
			held_pend_q <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Power-state machine

	reg [17:0] ms_cnt_q;
	reg [14:0] ms_q;
	wire ms_tick = ms_cnt_q == MS_CYCLES - 1;
	wire wake = bus_start || int_fall;

	always @* begin
		state_d = state_q;
		conv_req = 1'b0;
		case (state_q)
			ST_STBY: begin
				// [RULE_16] Bus trigger or pin
				conv_req = TRIG_I || int_fall;
			end
			ST_SLEEP: begin
				if (wake)
					state_d = ST_STBY;
			end
			ST_CONT: begin
				// [RULE_22] Back-to-back conversions
				conv_req = 1'b1;
			end
			ST_WS: begin
				// [RULE_19] [RULE_24] Wake at interval
				conv_req = ms_tick && ms_q + 15'd1 >= interval_ms(INTERVAL_SELECT_I);
				// [RULE_20] Host wakes it
				if (wake)
					state_d = ST_STBY;
				else if (woc_hit)
					state_d = ST_WAIT;
			end
			ST_WAIT: begin
				// [RULE_21] Read after interrupt ends in standby
				if (RD_ADDRESSED_I && int_pend_q)
					state_d = ST_STBY;
				else if (ms_tick && ms_q + 15'd1 >= `WAIT_MS)
					state_d = ST_WS;
			end
			default: state_d = ST_STBY;
		endcase
		if (state_q != ST_WAIT && RD_ADDRESSED_I && int_pend_q)
			state_d = ST_STBY;
		if (MODE_WR_I) begin
			case (MODE_I)
				`PWR_SLEEP: state_d = ST_SLEEP;
				`PWR_CONT: state_d = ST_CONT;
				`PWR_WAKESLEEP: state_d = ST_WS;
				default: state_d = ST_STBY;
			endcase
		end
	end

	always @(posedge CLK_I or negedge rst_b) begin
		if (!rst_b) begin
			// [RULE_15] Standby after power-up
			state_q <= ST_STBY;
			ms_cnt_q <= 18'd0;
			ms_q <= 15'd0;
			int_pend_q <= 1'b0;
			PWR_STATE_O <= ST_STBY;
		end else begin
			state_q <= state_d;
			PWR_STATE_O <= state_d;
			if (state_d != state_q || conv_start || ms_tick)
				ms_cnt_q <= 18'd0;
			else
				ms_cnt_q <= ms_cnt_q + 18'd1;
			if (state_d != state_q || conv_start)
				ms_q <= 15'd0;
			else if (ms_tick)
				ms_q <= ms_q + 15'd1;
			// Set wins over a same-cycle clear
			if (woc_hit)
				int_pend_q <= 1'b1;
			else if (RD_ADDRESSED_I)
				int_pend_q <= 1'b0;
		end
	end

endmodule // hall_mode_ctrl

// ==== bench/hall_mode_props.sv ====
// Port-level checker of the sensor mode control
`timescale 1ns/1ps
module hall_mode_props #(
	parameter MS_CYCLES = 200
) (
	input wire CLK_I, // Clock
	input wire RST_B_I, // Reset, low
	input wire REG_WR_I, // Reg write
	input wire [6:0] REG_PTR_I, // Reg pointer
	input wire [7:0] REG_WDATA_I, // Reg data
	input wire TRIG_I, // Trigger
	input wire RD_ADDRESSED_I, // Read addressed
	input wire MODE_WR_I, // Mode write
	input wire [2:0] INT_ROUTE_I, // Routing
	input wire XY_RANGE_I, // X/Y range
	input wire [6:0] BUS_ADDR_O, // Address
	input wire XY_SPAN_O, // X/Y span
	input wire CONV_BUSY_O, // Busy
	input wire INT_OE_O, // Pin pulse
	input wire SCL_OE_O, // Clock pulse
	input wire [2:0] PWR_STATE_O // State
);
	localparam int WAIT_CYC = 10 * MS_CYCLES;
	logic [11:0] pulse_q;
	logic [15:0] wait_q;
	default clocking @(posedge CLK_I); endclocking
	default disable iff (!RST_B_I);
	////////////////////////////////////////////////////////////////////////////////
	// Run lengths, since pulses and waits are far longer than a repetition
	always @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			pulse_q <= 12'h000;
			wait_q <= 16'h0000;
		end else begin
			pulse_q <= INT_OE_O ? pulse_q + 12'h001 : 12'h000;
			wait_q <= (PWR_STATE_O == 3'h4) ? wait_q + 16'h0001 : 16'h0000;
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	a_trig_start: assert property (
		TRIG_I && !CONV_BUSY_O && PWR_STATE_O == 3'h0 && !MODE_WR_I |=> CONV_BUSY_O)
		else $error("trigger did not start a conversion");
	a_addr_override: assert property (
		REG_WR_I && REG_PTR_I == 7'h0c && REG_WDATA_I[0]
		|-> ##2 BUS_ADDR_O == $past(REG_WDATA_I[7:1], 2))
		else $error("programmed address not used");
	a_pulse_len: assert property (
		$fell(INT_OE_O) |-> pulse_q == 12'h4e2)
		else $error("pin pulse length wrong");
	a_pin_route: assert property (
		$rose(INT_OE_O) |-> $past(INT_ROUTE_I) inside {3'h1, 3'h2})
		else $error("pin pulse on wrong route");
	a_clock_route: assert property (
		$rose(SCL_OE_O) |-> $past(INT_ROUTE_I) inside {3'h3, 3'h4})
		else $error("clock pulse on wrong route");
	a_switch_off: assert property (
		INT_ROUTE_I inside {3'h5, 3'h6} |=> !$rose(INT_OE_O) && !$rose(SCL_OE_O))
		else $error("change pulse in switch routing");
	a_wait_len: assert property (
		PWR_STATE_O == 3'h3 && $past(PWR_STATE_O) == 3'h4
		|-> wait_q >= WAIT_CYC - 1 && wait_q <= WAIT_CYC + 1)
		else $error("wait state length wrong");
	a_read_standby: assert property (
		RD_ADDRESSED_I && PWR_STATE_O == 3'h4 && !MODE_WR_I |-> ##[1:3] PWR_STATE_O == 3'h0)
		else $error("read after interrupt kept state");
	a_cont_again: assert property (
		PWR_STATE_O == 3'h2 && $fell(CONV_BUSY_O) && !MODE_WR_I |=> CONV_BUSY_O)
		else $error("continuous mode did not restart");
	a_span_load: assert property (
		$rose(CONV_BUSY_O) |-> XY_SPAN_O == $past(XY_RANGE_I))
		else $error("span not loaded at start");
	c_pin_pulse: cover property ($rose(INT_OE_O));
	c_clock_pulse: cover property ($rose(SCL_OE_O));
	c_wait_state: cover property (PWR_STATE_O == 3'h4);
endmodule // hall_mode_props

// ==== bench/i2c_host_model.sv ====
// Bus host model: pulled-up lines, start and stop frames, interrupt pin wake
`timescale 1ns/1ps
module i2c_host_model (
	input wire scl_oe_i, // Device pulls clock low
	input wire int_oe_i, // Device pulls pin low
	output wire scl_line_o, // Clock line level
	output wire sda_line_o, // Data line level
	output wire int_line_o // Pin line level
);
	logic scl_q = 1'b1;
	logic sda_q = 1'b1;
	logic int_q = 1'b1;
	// Pull-ups: low wins, clock stands high outside frames
	assign scl_line_o = scl_q & ~scl_oe_i;
	assign sda_line_o = sda_q;
	assign int_line_o = int_q & ~int_oe_i;
	task automatic start_cond();
		sda_q = 1'b0;
		#62.5 scl_q = 1'b0;
	endtask
	task automatic bits(input int k);
		repeat (k) begin
			#31 sda_q = ~sda_q;
			#31.5 scl_q = 1'b1;
			#62.5 scl_q = 1'b0;
		end
	endtask
	task automatic stop_cond();
		#31 sda_q = 1'b0;
		#31.5 scl_q = 1'b1;
		#62.5 sda_q = 1'b1;
	endtask
	task automatic pulse_int();
		int_q = 1'b0;
		#200 int_q = 1'b1;
	endtask
endmodule // i2c_host_model

// ==== bench/hall_sensor_mode_control_bench.sv ====
// Self-checking bench of the sensor mode control
`timescale 1ns/1ps
module hall_sensor_mode_control_bench;
	localparam int MS = 200;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic wr = 1'b0, trig = 1'b0, rd_addr = 1'b0, mode_wr = 1'b0, xyr = 1'b0, zr = 1'b0;
	logic [1:0] strap = 2'h0, mode = 2'h0, watch = 2'h0;
	logic [2:0] axes = 3'h1, route = 3'h0, avg = 3'h0;
	logic [3:0] ivl = 4'h0;
	logic [6:0] ptr = 7'h0c;
	logic [7:0] wdata = 8'h00;
	logic [15:0] x = 16'h0000, y = 16'h0000, ang = 16'h0000, v;
	logic [31:0] seed = 32'h64e8c7e8;
	wire [7:0] rdata;
	wire [6:0] bus_addr;
	wire [15:0] rx, ry, ra;
	wire [2:0] pst;
	wire xys, zs, busy, scl_oe, int_oe, scl_line, sda_line, int_line;
	int err_count = 0, checks_done = 0, cycles = 0, n, t0;
	int rt[16] = '{1, 1, 1, 1, 1, 1, 1, 1, 1, 2, 2, 3, 4, 0, 5, 6};
	int wt[16] = '{2, 2, 2, 2, 2, 1, 1, 1, 1, 2, 2, 2, 2, 2, 2, 2};
	int vl[16] = '{1000, 1100, 1101, 1201, 1000, 0, 359, 0, 50, 1000, 4000, 8000, 12000,
		16000, 20000, 24000};
	// 2 marks an unchecked sample: the first reference load, or a compare against the previous source's reference
	int ex[16] = '{2, 0, 1, 0, 1, 2, 1, 1, 0, 2, 1, 1, 1, 0, 0, 0};
	hall_mode_ctrl #(.MS_CYCLES(MS), .RATE_DIV(100)) hall_mode_ctrl_inst (
		.CLK_I(clk), .RST_B_I(rst_b), .SCL_I(scl_line), .SDA_I(sda_line), .SCL_O(),
		.SCL_OE_O(scl_oe), .INT_B_I(int_line), .INT_B_O(), .INT_OE_O(int_oe),
		.ADDR_STRAP_I(strap), .REG_PTR_I(ptr), .REG_WR_I(wr), .REG_WDATA_I(wdata),
		.REG_RDATA_O(rdata), .TRIG_I(trig), .RD_ADDRESSED_I(rd_addr), .MODE_WR_I(mode_wr),
		.MODE_I(mode), .CHANGE_WATCH_SELECT_I(watch), .FIELD_AXIS_ENABLE_I(axes),
		.FIELD_HYSTERESIS_I(16'h0064), .ANGLE_HYSTERESIS_I(16'h012c), .INT_ROUTE_I(route),
		.AVERAGING_SELECT_I(avg), .INTERVAL_SELECT_I(ivl), .XY_RANGE_I(xyr), .Z_RANGE_I(zr),
		.X_I(x), .Y_I(y), .Z_I(y), .ANGLE_I(ang), .BUS_ADDR_O(bus_addr), .XY_SPAN_O(xys),
		.Z_SPAN_O(zs), .CONV_BUSY_O(busy), .RES_X_O(rx), .RES_Y_O(ry), .RES_Z_O(),
		.RES_ANGLE_O(ra), .PWR_STATE_O(pst));
	i2c_host_model i2c_host_model_inst (.scl_oe_i(scl_oe), .int_oe_i(int_oe),
		.scl_line_o(scl_line), .sda_line_o(sda_line), .int_line_o(int_line));
	always #2 clk = ~clk;
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 90000) begin
			err_count++;
			finish_test();
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic int conv_len(input int ax);
		return (ax == 1 ? 12500 : 25000) / 100;
	endfunction
	function automatic int ivl_cyc(input int c);
		int t[13] = '{1, 5, 10, 15, 20, 30, 50, 100, 500, 1000, 2000, 5000, 20000};
		return t[c] * MS;
	endfunction
	task automatic cyc(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask
	task automatic rnd();
		seed = lfsr(seed);
		y = seed[31:16];
	endtask
	task automatic cmp(input string nm, input logic [15:0] e, input logic [15:0] g);
		checks_done++;
		if (g !== e) begin
			err_count++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wreg(input logic [7:0] d);
		ptr = 7'h0c;
		wdata = d;
		wr = 1'b1;
		cyc(1);
		wr = 1'b0;
		cyc(4);
	endtask
	task automatic setmode(input logic [1:0] m);
		mode = m;
		mode_wr = 1'b1;
		cyc(1);
		mode_wr = 1'b0;
		cyc(3);
	endtask
	// Second trigger mid-conversion must be ignored
	task automatic convert();
		trig = 1'b1;
		cyc(1);
		n = 0;
		while (busy === 1'b1 && n < 5000) begin
			trig = (n == 9);
			cyc(1);
			n++;
		end
		trig = 1'b0;
		cyc(3);
	endtask
	task automatic wait_pst(input logic [2:0] s, input int lim);
		n = 0;
		while (pst !== s && n < lim) begin
			cyc(1);
			n++;
		end
	endtask
	task automatic next_rise();
		n = 0;
		while (busy !== 1'b0 && n < 9000) begin
			cyc(1);
			n++;
		end
		while (busy !== 1'b1 && n < 9000) begin
			cyc(1);
			n++;
		end
	endtask
	task automatic finish_test();
		if (err_count == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		cyc(8);
		rst_b = 1'b1;
		cyc(3);
		cmp("state", 16'h0000, 16'(pst));
		cmp("addr reg", 16'h0000, 16'(rdata));
		for (int s = 0; s < 4; s++) begin
			strap = 2'(s);
			cyc(6);
			cmp("strap addr", 16'(7'h34 + s), 16'(bus_addr));
		end
		repeat (3) begin
			rnd();
			wreg({seed[6:0], 1'b1});
			cmp("ovr addr", 16'(seed[6:0]), 16'(bus_addr));
			cmp("addr reg", 16'({seed[6:0], 1'b1}), 16'(rdata));
		end
		wreg(8'h6d);
		cmp("ovr addr", 16'h0036, 16'(bus_addr));
		ptr = 7'h0d;
		wdata = 8'hff;
		wr = 1'b1;
		cyc(1);
		wr = 1'b0;
		cyc(2);
		cmp("unmapped", 16'h0000, 16'(rdata));
		ptr = 7'h0c;
		cyc(2);
		cmp("addr reg", 16'h006d, 16'(rdata));
		strap = 2'h2;
		wreg(8'h00);
		x = 16'h1234;
		convert();
		cmp("res x", 16'h1234, rx);
		setmode(2'h1);
		cmp("sleep res", 16'h0000, rx);
		strap = 2'h0;
		cyc(8);
		cmp("sleep addr", 16'h0036, 16'(bus_addr));
		i2c_host_model_inst.start_cond();
		i2c_host_model_inst.stop_cond();
		cyc(8);
		cmp("bus wake", 16'h0000, 16'(pst));
		cmp("resample", 16'h0034, 16'(bus_addr));
		x = 16'h0abc;
		i2c_host_model_inst.pulse_int();
		cyc(200);
		cmp("pin conv", 16'h0abc, rx);
		for (int a = 0; a < 6; a++) begin
			avg = 3'(a);
			xyr = a[0];
			zr = ~a[0];
			rnd();
			x = seed[15:0];
			convert();
			cmp("xy span", 16'(xyr), 16'(xys));
			cmp("z span", 16'(zr), 16'(zs));
			cmp("res x", x, rx);
			cmp("res y", y, ry);
			if (a == 0)
				cmp("conv len", 16'(conv_len(1)), 16'(n));
			else
				cmp("slower", 16'h0001, 16'(n > t0));
			t0 = n;
		end
		avg = 3'h0;
		axes = 3'h7;
		convert();
		cmp("conv len", 16'(conv_len(3)), 16'(n));
		axes = 3'h1;
		v = rx;
		i2c_host_model_inst.start_cond();
		cyc(4);
		x = ~v;
		convert();
		cmp("frozen", v, rx);
		i2c_host_model_inst.bits(9);
		i2c_host_model_inst.stop_cond();
		cyc(8);
		cmp("after stop", ~v, rx);
		setmode(2'h2);
		repeat (2) begin
			rnd();
			x = seed[15:0];
			cyc(400);
			cmp("cont res", x, rx);
		end
		setmode(2'h0);
		cyc(300);
		for (int i = 0; i < 16; i++) begin
			route = 3'(rt[i]);
			watch = 2'(wt[i]);
			if (wt[i] == 2)
				x = 16'(vl[i]);
			else
				ang = 16'(vl[i]);
			convert();
			if (ex[i] != 2)
				cmp("change", 16'(ex[i]), 16'(int_oe | scl_oe));
			cyc(1300);
		end
		route = 3'h1;
		convert();
		cmp("res ang", ang, ra);
		cyc(1300);
		wreg(8'h6d);
		for (int c = 0; c < 2; c++) begin
			ivl = 4'(c);
			setmode(2'h3);
			next_rise();
			t0 = cycles;
			next_rise();
			t0 = cycles - t0;
			cmp("interval", 16'h0001, 16'(t0 >= ivl_cyc(c) - 2 && t0 <= ivl_cyc(c) + 2));
		end
		x = 16'h0000;
		wait_pst(3'h4, 3000);
		cmp("wait", 16'h0004, 16'(pst));
		cmp("held", 16'h0000, rx);
		wait_pst(3'h3, 2100);
		cmp("resume", 16'h0003, 16'(pst));
		i2c_host_model_inst.pulse_int();
		cyc(8);
		cmp("pin wake", 16'h0000, 16'(pst));
		setmode(2'h3);
		x = 16'h1388;
		wait_pst(3'h4, 3000);
		rd_addr = 1'b1;
		cyc(1);
		rd_addr = 1'b0;
		cyc(4);
		cmp("read wake", 16'h0000, 16'(pst));
		setmode(2'h3);
		i2c_host_model_inst.start_cond();
		i2c_host_model_inst.stop_cond();
		cyc(8);
		cmp("bus wake", 16'h0000, 16'(pst));
		finish_test();
	end
endmodule // hall_sensor_mode_control_bench

bind hall_mode_ctrl hall_mode_props #(.MS_CYCLES(MS_CYCLES)) hall_mode_props_inst (
	.CLK_I(CLK_I), .RST_B_I(RST_B_I), .REG_WR_I(REG_WR_I), .REG_PTR_I(REG_PTR_I),
	.REG_WDATA_I(REG_WDATA_I), .TRIG_I(TRIG_I), .RD_ADDRESSED_I(RD_ADDRESSED_I),
	.MODE_WR_I(MODE_WR_I), .INT_ROUTE_I(INT_ROUTE_I), .XY_RANGE_I(XY_RANGE_I),
	.BUS_ADDR_O(BUS_ADDR_O), .XY_SPAN_O(XY_SPAN_O), .CONV_BUSY_O(CONV_BUSY_O),
	.INT_OE_O(INT_OE_O), .SCL_OE_O(SCL_OE_O), .PWR_STATE_O(PWR_STATE_O));
